// ### core/airc_defs.vh
`ifndef AIRC_DEFS_VH
`define AIRC_DEFS_VH
// Register byte addresses on the APB port.
`define AIRC_ADDR_INPUT_CLOCK 12'h000
`define AIRC_ADDR_REFERENCE 12'h004
`define AIRC_ADDR_CHANNEL 12'h008
`define AIRC_ADDR_PIN_ENABLE 12'h00c
`define AIRC_ADDR_STATUS 12'h010
// Reset values.
`define AIRC_RST_INPUT_CLOCK 8'h00
`define AIRC_RST_REFERENCE 8'h00
`define AIRC_RST_CHANNEL 3'h0
`define AIRC_RST_PIN_ENABLE 8'hff
// Field positions in the input and clock control register.
`define AIRC_CKDIV_LSB 0
`define AIRC_CKDIV_MSB 2
`define AIRC_INSRC_LSB 5
`define AIRC_INSRC_MSB 7
// Field positions in the reference control register.
`define AIRC_REFSRC_LSB 0
`define AIRC_REFSRC_MSB 3
`define AIRC_REFOUT_BIT 4
`define AIRC_EXTREF_BIT 5
`define AIRC_BGEN_BIT 6
`define AIRC_AMPEN_BIT 7
// Field positions in the channel select and status registers.
`define AIRC_CHAN_LSB 0
`define AIRC_CHAN_MSB 2
`define AIRC_STATUS_LSB 0
`define AIRC_STATUS_MSB 3
// Writable bit mask of the input and clock control register.
`define AIRC_MASK_INPUT_CLOCK 8'he7
// Input source codes.
`define AIRC_IN_EXT_A 3'h0
`define AIRC_IN_VDD 3'h1
`define AIRC_IN_VDD2 3'h2
`define AIRC_IN_VDD4 3'h3
`define AIRC_IN_EXT_B 3'h4
`define AIRC_IN_VR 3'h5
`define AIRC_IN_VR2 3'h6
`define AIRC_IN_VR4 3'h7
// Reference source codes.
`define AIRC_REF_VDD 4'h0
`define AIRC_REF_EXT1 4'h1
`define AIRC_REF_EXT2 4'h2
`define AIRC_REF_EXT3 4'h3
`define AIRC_REF_EXT4 4'h4
`define AIRC_REF_RSVD 4'h9
`define AIRC_REF_BG2 4'ha
`define AIRC_REF_BG3 4'hb
`define AIRC_REF_BG4 4'hc
// Reference path selector encoding.
`define AIRC_PATH_VDD 2'h0
`define AIRC_PATH_EXT 2'h1
`define AIRC_PATH_BG 2'h2
// Internal signal selector encoding.
`define AIRC_SIG_EXT 3'h0
`define AIRC_SIG_VDD 3'h1
`define AIRC_SIG_VDD2 3'h2
`define AIRC_SIG_VDD4 3'h3
`define AIRC_SIG_VR 3'h5
`define AIRC_SIG_VR2 3'h6
`define AIRC_SIG_VR4 3'h7
`endif

// ### core/airc_adc_ctrl.v
// What this block does
// - Converter clock is system clock over 2^code.
// - Amplifier enable exposes amplified reference to converter.
// - Bandgap on when enabled and used by a bandgap reference or the amplifier, or needed by the supply monitors.
// - Bits select reference input and output pins.
// - Reference code picks supply, pin, or bandgap.
// - Bandgap reference disconnects supply and pin paths.
// - Analog enable removes pin digital functions.
// - Analog enable removes pin pull-high.
// - Analog enable overrides pin direction control.
// - Source 000 or 100 converts external channel.
// - Other source codes pick internal signals.
// - Internal signal disconnects all external channels.
// - Reference gain 1 to 4 except supply.
// - Selected reference drives reference output pin.
// - Eight analog enables reset to one.
`include "airc_defs.vh"
module airc_adc_ctrl #(
  parameter NPINS = 8
) (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire supply_drop_detector_en,
  input wire supply_drop_reset_en,
  input wire [NPINS-1:0] pin_pull_high_cfg,
  input wire [NPINS-1:0] pin_output_enable_cfg,
  output reg conv_clk_en,
  output reg bandgap_power,
  output reg ref_amp_power,
  output reg [1:0] ref_path_sel,
  output reg ref_supply_connect,
  output reg ref_ext_pin_connect,
  output reg ref_bandgap_connect,
  output reg [2:0] ref_gain,
  output reg ref_output_drive,
  output reg ext_ref_pin_func,
  output reg ref_output_pin_func,
  output reg [2:0] conv_signal_sel,
  output reg [NPINS-1:0] channel_connect,
  output reg [NPINS-1:0] pin_digital_disable,
  output reg [NPINS-1:0] pin_pull_high_eff,
  output reg [NPINS-1:0] pin_output_enable_eff
);

  // Software-visible configuration registers, then divider and read-mux working signals.
  reg [7:0] input_clock_reg;
  reg [7:0] reference_reg;
  reg [2:0] channel_reg;
  reg [NPINS-1:0] analog_pin_enable_reg;
  reg [6:0] div_count_reg;
  reg [6:0] div_count_next;
  reg [6:0] div_mask;
  reg conv_clk_en_next;
  reg [31:0] rdata_next;
  reg addr_ok;
  // Next values of the APB answer flops.
  reg pready_next;
  reg pslverr_next;
  reg [31:0] prdata_next;
  // Shared reference path decode, then next values of the analog control flops.
  reg [1:0] ref_path_now;
  reg bandgap_power_next;
  reg ref_amp_power_next;
  reg [1:0] ref_path_sel_next;
  reg ref_supply_connect_next;
  reg ref_ext_pin_connect_next;
  reg ref_bandgap_connect_next;
  reg [2:0] ref_gain_next;
  reg ref_output_drive_next;
  reg ext_ref_pin_func_next;
  reg ref_output_pin_func_next;
  reg [2:0] conv_signal_sel_next;
  reg [NPINS-1:0] channel_connect_next;
  reg [NPINS-1:0] pin_digital_disable_next;
  reg [NPINS-1:0] pin_pull_high_eff_next;
  reg [NPINS-1:0] pin_output_enable_eff_next;

  // Named fields of the two control registers.
  wire [2:0] conv_clock_div_sel = input_clock_reg[`AIRC_CKDIV_MSB:`AIRC_CKDIV_LSB];
  wire [2:0] input_source_sel = input_clock_reg[`AIRC_INSRC_MSB:`AIRC_INSRC_LSB];
  wire [3:0] reference_source_sel = reference_reg[`AIRC_REFSRC_MSB:`AIRC_REFSRC_LSB];
  wire ref_amplifier_enable = reference_reg[`AIRC_AMPEN_BIT];
  wire bandgap_enable = reference_reg[`AIRC_BGEN_BIT];
  wire ext_ref_pin_select = reference_reg[`AIRC_EXTREF_BIT];
  wire ref_output_pin_select = reference_reg[`AIRC_REFOUT_BIT];

  // Setup phase of the APB handshake.
  wire apb_setup = psel & ~penable;
  // A write lands only on the edge where pready is sampled high, so a held access phase never writes twice.
  wire apb_write = psel & penable & pwrite & pready;

  // Reference path for a reference code; reserved and unlisted codes fall back to supply.
  function [1:0] ref_path;
    input [3:0] code;
    begin
      case (code)
        `AIRC_REF_EXT1, `AIRC_REF_EXT2, `AIRC_REF_EXT3, `AIRC_REF_EXT4: ref_path = `AIRC_PATH_EXT;
        `AIRC_REF_BG2, `AIRC_REF_BG3, `AIRC_REF_BG4: ref_path = `AIRC_PATH_BG;
        default: ref_path = `AIRC_PATH_VDD;
      endcase
    end
  endfunction

  // Amplifier gain for a reference code; supply sources bypass the amplifier with gain one.
  function [2:0] ref_gain_of;
    input [3:0] code;
    begin
      case (code)
        `AIRC_REF_EXT2, `AIRC_REF_BG2: ref_gain_of = 3'h2;
        `AIRC_REF_EXT3, `AIRC_REF_BG3: ref_gain_of = 3'h3;
        `AIRC_REF_EXT4, `AIRC_REF_BG4: ref_gain_of = 3'h4;
        default: ref_gain_of = 3'h1;
      endcase
    end
  endfunction

  // True when the input source code picks an external channel.
  function is_external;
    input [2:0] src;
    begin
      is_external = (src == `AIRC_IN_EXT_A) || (src == `AIRC_IN_EXT_B);
    end
  endfunction

  // Register writes land on the access edge; the slave never waits.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_clock_reg <= `AIRC_RST_INPUT_CLOCK;
      reference_reg <= `AIRC_RST_REFERENCE;
      channel_reg <= `AIRC_RST_CHANNEL;
      analog_pin_enable_reg <= {NPINS{1'b1}};
    end else if (apb_write) begin
      case (paddr)
        // Bits 4 and 3 are not implemented, so the mask keeps them at zero.
        `AIRC_ADDR_INPUT_CLOCK: begin
          input_clock_reg <= pwdata[7:0] & `AIRC_MASK_INPUT_CLOCK;
        end
        // Every bit of the reference control register is writable.
        `AIRC_ADDR_REFERENCE: begin
          reference_reg <= pwdata[7:0];
        end
        // Only the channel field is kept.
        `AIRC_ADDR_CHANNEL: begin
          channel_reg <= pwdata[`AIRC_CHAN_MSB:`AIRC_CHAN_LSB];
        end
        // One enable bit per shared pin.
        `AIRC_ADDR_PIN_ENABLE: begin
          analog_pin_enable_reg <= pwdata[NPINS-1:0];
        end
        // Unmapped and read-only addresses store nothing.
        default: begin
        end
      endcase
    end
  end

  // Read mux; the status word shows the live power and path state.
  always @* begin
    rdata_next = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `AIRC_ADDR_INPUT_CLOCK: rdata_next[7:0] = input_clock_reg;
      `AIRC_ADDR_REFERENCE: rdata_next[7:0] = reference_reg;
      `AIRC_ADDR_CHANNEL: rdata_next[`AIRC_CHAN_MSB:`AIRC_CHAN_LSB] = channel_reg;
      `AIRC_ADDR_PIN_ENABLE: rdata_next[NPINS-1:0] = analog_pin_enable_reg;
      // The status word is read-only; a write to it is taken and ignored.
      `AIRC_ADDR_STATUS: rdata_next[`AIRC_STATUS_MSB:`AIRC_STATUS_LSB] = {ref_path_sel, ref_amp_power, bandgap_power};
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero-wait APB answer: pready rises as the access phase begins.
  always @* begin
    pready_next = apb_setup;
    pslverr_next = apb_setup & ~addr_ok;
    // Idle read data is zero so a stale word never sits on the bus.
    prdata_next = 32'h00000000;
    if (apb_setup && !pwrite) begin
      prdata_next = rdata_next;
    end
  end

  // Answer flops; the mux is sampled at the setup edge, so read data stands in the access cycle.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= pready_next;
      pslverr <= pslverr_next;
      prdata <= prdata_next;
    end
  end

  // Free-running counter; a mask of low bits gives a pulse every 2^code cycles.
  // Code seven shifts the one out of the seven bits and the subtraction wraps to the all-ones mask.
  // The counter is never restarted, so the first period after a code change may be short.
  always @* begin
    div_count_next = div_count_reg + 7'h01;
    div_mask = (7'h01 << conv_clock_div_sel) - 7'h01;
    conv_clk_en_next = ((div_count_reg & div_mask) == 7'h00);
  end

  // Counter and enable flop.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_count_reg <= 7'h00;
      conv_clk_en <= 1'b0;
    end else begin
      div_count_reg <= div_count_next;
      conv_clk_en <= conv_clk_en_next;
    end
  end

  // Reference path decoded once and shared by the power and switch logic.
  always @* begin
    ref_path_now = ref_path(reference_source_sel);
    // Bandgap stays up for the supply monitors even when the converter drops it.
    bandgap_power_next = (bandgap_enable && ((ref_path_now == `AIRC_PATH_BG) || ref_amplifier_enable)) ||
                         supply_drop_detector_en || supply_drop_reset_en;
    ref_amp_power_next = ref_amplifier_enable;
    ref_path_sel_next = ref_path_now;
    // Only one source switch closes at a time, so a bandgap reference opens the other two.
    ref_supply_connect_next = (ref_path_now == `AIRC_PATH_VDD);
    // The pin path also waits for the pin to be claimed, else it would fight the pin's other role.
    ref_ext_pin_connect_next = (ref_path_now == `AIRC_PATH_EXT) && ext_ref_pin_select;
    ref_bandgap_connect_next = (ref_path_now == `AIRC_PATH_BG);
    // Supply codes bypass the amplifier and report unity gain.
    ref_gain_next = ref_gain_of(reference_source_sel);
    // The output buffer follows its select bit and carries whichever reference is chosen.
    ref_output_drive_next = ref_output_pin_select;
    ext_ref_pin_func_next = ext_ref_pin_select;
    ref_output_pin_func_next = ref_output_pin_select;
  end

  // Converted signal and channel switches; internal codes pass through as the selector.
  always @* begin
    if (is_external(input_source_sel)) begin
      conv_signal_sel_next = `AIRC_SIG_EXT;
      channel_connect_next = analog_pin_enable_reg & ({{(NPINS-1){1'b0}}, 1'b1} << channel_reg);
    end else begin
      // Internal signals open every channel switch so no pad fights the internal node.
      conv_signal_sel_next = input_source_sel;
      channel_connect_next = {NPINS{1'b0}};
    end
  end

  // Pin overrides: an analog pin loses digital function, pull-high and direction control.
  // The configured settings are kept, so clearing an enable gives the pin its old setup back.
  always @* begin
    pin_digital_disable_next = analog_pin_enable_reg;
    pin_pull_high_eff_next = pin_pull_high_cfg & ~analog_pin_enable_reg;
    pin_output_enable_eff_next = pin_output_enable_cfg & ~analog_pin_enable_reg;
  end

  // Analog control outputs are registered so each pad sees a clean level.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bandgap_power <= 1'b0;
      ref_amp_power <= 1'b0;
      ref_path_sel <= `AIRC_PATH_VDD;
      ref_supply_connect <= 1'b1;
      ref_ext_pin_connect <= 1'b0;
      ref_bandgap_connect <= 1'b0;
      ref_gain <= 3'h1;
      ref_output_drive <= 1'b0;
      ext_ref_pin_func <= 1'b0;
      ref_output_pin_func <= 1'b0;
      conv_signal_sel <= `AIRC_SIG_EXT;
      channel_connect <= {NPINS{1'b0}};
      pin_digital_disable <= {NPINS{1'b1}};
      pin_pull_high_eff <= {NPINS{1'b0}};
      pin_output_enable_eff <= {NPINS{1'b0}};
    end else begin
      bandgap_power <= bandgap_power_next;
      ref_amp_power <= ref_amp_power_next;
      ref_path_sel <= ref_path_sel_next;
      ref_supply_connect <= ref_supply_connect_next;
      ref_ext_pin_connect <= ref_ext_pin_connect_next;
      ref_bandgap_connect <= ref_bandgap_connect_next;
      ref_gain <= ref_gain_next;
      ref_output_drive <= ref_output_drive_next;
      ext_ref_pin_func <= ext_ref_pin_func_next;
      ref_output_pin_func <= ref_output_pin_func_next;
      conv_signal_sel <= conv_signal_sel_next;
      channel_connect <= channel_connect_next;
      pin_digital_disable <= pin_digital_disable_next;
      pin_pull_high_eff <= pin_pull_high_eff_next;
      pin_output_enable_eff <= pin_output_enable_eff_next;
    end
  end

endmodule

// ### sim/airc_adc_ctrl_properties.sv
module airc_chk #(parameter NPINS = 8) (
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire supply_drop_detector_en,
  input wire bandgap_power,
  input wire [1:0] ref_path_sel,
  input wire ref_supply_connect,
  input wire ref_ext_pin_connect,
  input wire [2:0] ref_gain,
  input wire ext_ref_pin_func,
  input wire [2:0] conv_signal_sel,
  input wire [NPINS-1:0] channel_connect,
  input wire [NPINS-1:0] pin_digital_disable,
  input wire [NPINS-1:0] pin_pull_high_eff,
  input wire [NPINS-1:0] pin_output_enable_eff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Zero-wait slave: one ready pulse per setup, error only with it.
  chk_ready_one_pulse: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad pready");
  chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_bandgap_kept_on: assert property (supply_drop_detector_en |=> bandgap_power) else $error("bandgap off");
  chk_bandgap_isolates: assert property (ref_path_sel == 2'h2 |-> !ref_supply_connect && !ref_ext_pin_connect)
    else $error("bandgap path not isolated");
  chk_supply_unity_gain: assert property (ref_path_sel == 2'h0 |-> ref_gain == 3'h1 && ref_supply_connect)
    else $error("supply path gain");
  chk_ext_needs_pin: assert property (ref_ext_pin_connect |-> ext_ref_pin_func) else $error("pin not selected");
  chk_internal_isolates: assert property (conv_signal_sel != 3'h0 |-> channel_connect == 0)
    else $error("channel left connected");
  chk_channel_enabled: assert property ($onehot0(channel_connect) && !(channel_connect & ~pin_digital_disable))
    else $error("bad channel connect");
  chk_pull_high_off: assert property (!(pin_pull_high_eff & pin_digital_disable)) else $error("pull-high kept");
  chk_dir_override: assert property (!(pin_output_enable_eff & pin_digital_disable)) else $error("driver kept");
  // Main scenarios reached.
  cover property (conv_signal_sel == 3'h7);
  cover property (ref_path_sel == 2'h2);
  cover property (pslverr);
endmodule
bind airc_adc_ctrl airc_chk #(.NPINS(NPINS)) chk_u (.clk, .reset_n, .psel, .penable, .pready, .pslverr,
  .supply_drop_detector_en, .bandgap_power, .ref_path_sel, .ref_supply_connect, .ref_ext_pin_connect, .ref_gain,
  .ext_ref_pin_func, .conv_signal_sel, .channel_connect, .pin_digital_disable, .pin_pull_high_eff,
  .pin_output_enable_eff);

// ### sim/airc_core_model.sv
module airc_core_model (
  input wire clk,
  input wire reset_n,
  input wire conv_clk_en,
  output logic [15:0] tick_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // The core steps once per divider pulse; the count lets the bench see the ratio.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_count <= 16'h0000;
    end else if (conv_clk_en) begin
      tick_count <= tick_count + 16'h0001;
    end
  end
endmodule

// ### sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, conv_clk_en, bandgap_power, ref_amp_power, ref_supply_connect, ref_ext_pin_connect;
  logic ref_bandgap_connect, ref_output_drive, ext_ref_pin_func, ref_output_pin_func;
  logic supply_drop_detector_en = 1'b0, supply_drop_reset_en = 1'b0;
  logic [1:0] ref_path_sel, ep;
  logic [2:0] ref_gain, conv_signal_sel, eg;
  logic [7:0] pin_pull_high_cfg = 8'hff, pin_output_enable_cfg = 8'hff, channel_connect, pin_digital_disable;
  logic [7:0] pin_pull_high_eff, pin_output_enable_eff;
  logic [15:0] ticks, t0;
  int fails = 0, n_checks = 0, i;
  airc_adc_ctrl dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .supply_drop_detector_en, .supply_drop_reset_en, .pin_pull_high_cfg, .pin_output_enable_cfg, .conv_clk_en,
    .bandgap_power, .ref_amp_power, .ref_path_sel, .ref_supply_connect, .ref_ext_pin_connect, .ref_bandgap_connect,
    .ref_gain, .ref_output_drive, .ext_ref_pin_func, .ref_output_pin_func, .conv_signal_sel, .channel_connect,
    .pin_digital_disable, .pin_pull_high_eff, .pin_output_enable_eff);
  airc_core_model core_u (.clk, .reset_n, .conv_clk_en, .tick_count(ticks));
  // A 5 ns system clock.
  initial forever #2.5 clk = ~clk;
  task final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the trailing wait lets derived outputs settle after a write.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Main sequence: reset values, refusal, divider, sources, references, pins.
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(0, 12'h00c, 0); cmp(rd, 32'hff);
    cmp(pin_digital_disable, 8'hff);
    apb(0, 12'h004, 0); cmp(rd, 0);
    apb(0, 12'h020, 0); cmp(rd, 0); cmp(err, 1);
    apb(1, 12'h000, 32'hff); apb(0, 12'h000, 0); cmp(rd, 32'he7);
    for (i = 0; i < 8; i++) begin
      apb(1, 12'h000, i);
      t0 = ticks;
      repeat (256) @(posedge clk);
      cmp(ticks - t0, 256 >> i);
    end
    apb(1, 12'h008, 5);
    for (i = 0; i < 8; i++) begin
      apb(1, 12'h000, i << 5);
      cmp(conv_signal_sel, (i % 4 == 0) ? 0 : i);
      cmp(channel_connect, (i % 4 == 0) ? 8'h20 : 8'h00);
    end
    for (i = 0; i < 16; i++) begin
      apb(1, 12'h004, 8'h30 | i);
      ep = (i >= 1 && i <= 4) ? 1 : (i >= 10 && i <= 12) ? 2 : 0;
      eg = (ep == 0) ? 1 : (ep == 1) ? i : i - 8;
      cmp(ref_path_sel, ep);
      cmp(ref_gain, eg);
      cmp({ref_supply_connect, ref_ext_pin_connect, ref_bandgap_connect}, {ep == 0, ep == 1, ep == 2});
      cmp({ext_ref_pin_func, ref_output_pin_func, ref_output_drive}, 3'h7);
    end
    apb(1, 12'h004, 8'hca); cmp({bandgap_power, ref_amp_power}, 2'h3);
    // Settle time for the bandgap before any conversion would start.
    repeat (64) @(posedge clk); cmp(bandgap_power, 1);
    apb(1, 12'h004, 8'h00); cmp(bandgap_power, 0);
    supply_drop_detector_en <= 1'b1;
    supply_drop_reset_en <= 1'b1;
    // The monitors reach the bandgap flop one edge later, and the status mux follows that flop with no further edge.
    repeat (2) @(posedge clk);
    apb(0, 12'h010, 0); cmp(rd, 1);
    apb(1, 12'h000, 0);
    apb(1, 12'h00c, 8'h0f); cmp({pin_digital_disable, pin_pull_high_eff, pin_output_enable_eff}, 24'h0ff0f0);
    cmp(channel_connect, 0);
    apb(1, 12'h008, 2); cmp(channel_connect, 8'h04);
    final_report;
  end
endmodule
